// ==== txsm_consts.vh ====
// constants for the transmit slot mask and interrupt enable block
`ifndef TXSM_CONSTS_VH
`define TXSM_CONSTS_VH

// register byte offsets
`define TXSM_OFS_SLOT_MASK    8'hb8
`define TXSM_OFS_INT_ENABLE   8'hbc
`define TXSM_OFS_STATUS       8'hc0
`define TXSM_OFS_FRAME_LEN    8'hc4

// reset values
`define TXSM_RST_SLOT_MASK    32'h0000_0000
`define TXSM_RST_INT_ENABLE   8'h00
`define TXSM_RST_FRAME_LEN    9'h000

// slot counter limits
`define TXSM_SLOT_MAX_LAST    9'h17f
`define TXSM_SLOT_W           9

// condition bit positions, shared by interrupt enable and internal flags
`define TXSM_BIT_UNDERRUN     0
`define TXSM_BIT_UNEXP_SYNC   1
`define TXSM_BIT_CLK_FAIL     2
`define TXSM_BIT_PORT_ERR     3
`define TXSM_BIT_FINAL_SLOT   4
`define TXSM_BIT_BUF_READY    5
`define TXSM_BIT_RESERVED     6
`define TXSM_BIT_FRAME_START  7
`define TXSM_INT_WRITE_MASK   8'hbf

// status register field positions
`define TXSM_ST_UNDERRUN      0
`define TXSM_ST_UNEXP_SYNC    1
`define TXSM_ST_CLK_FAIL      2
`define TXSM_ST_SLOT_ACTIVE   3
`define TXSM_ST_FINAL_SLOT    4
`define TXSM_ST_BUF_READY     5
`define TXSM_ST_FRAME_START   6
`define TXSM_ST_PORT_ERR      7
`define TXSM_ST_ERR_SUMMARY   8

`endif

// ==== txsm_slot_counter.v ====
// transmit time-division slot counter, up to 384 slots per frame
`timescale 1ns/10ps
`include "txsm_consts.vh"

module txsm_slot_counter (
    // clock and reset
    input  wire                      clk_sys_in,
    input  wire                      rst_b_in,
    input  wire                      clk_en_in,
    // control
    input  wire                      frame_start_in,
    input  wire                      slot_tick_in,
    input  wire [`TXSM_SLOT_W-1:0]   last_index_in,
    // state
    output reg  [`TXSM_SLOT_W-1:0]   slot_index_out,
    output reg                       running_out,
    output wire                      at_last_out
);

    reg  [`TXSM_SLOT_W-1:0] last_clamped;

    // a frame longer than the counter range is cut at 384 slots
    always @* begin
        if (last_index_in > `TXSM_SLOT_MAX_LAST) begin
            last_clamped = `TXSM_SLOT_MAX_LAST;
        end else begin
            last_clamped = last_index_in;
        end
    end

    assign at_last_out = running_out && (slot_index_out == last_clamped);

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slot_index_out <= {`TXSM_SLOT_W{1'b0}};
            running_out    <= 1'b0;
        end else if (clk_en_in) begin
            if (frame_start_in) begin
                slot_index_out <= {`TXSM_SLOT_W{1'b0}};
                running_out    <= 1'b1;
            end else if (slot_tick_in && running_out) begin
                if (slot_index_out == last_clamped) begin
                    // frame done; idle until the next frame sync
                    running_out <= 1'b0;
                end else begin
                    slot_index_out <= slot_index_out + 9'h001;
                end
            end
        end
    end

endmodule

// ==== txsm_top.v ====
// transmit slot activity mask, condition flags and transmit interrupt
`timescale 1ns/10ps
`include "txsm_consts.vh"

module txsm_top (
    // clock, enable and reset
    input  wire        clk_sys_in,
    input  wire        clk_en_in,
    input  wire        rst_b_in,
    // register port
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [31:0] reg_rdata_out,
    // serial side
    input  wire        tx_frame_sync_in,
    input  wire        slot_tick_in,
    // transmit condition events from the serializer logic
    input  wire        tx_buffer_empty_in,
    input  wire        tx_underrun_in,
    input  wire        tx_clock_failure_in,
    input  wire        tx_port_access_error_in,
    // slot state
    output reg         tx_slot_active_bit_out,
    output reg  [8:0]  tx_slot_index_out,
    output reg         tx_final_slot_out,
    // interrupt, dma and summary
    output reg         tx_interrupt_out,
    output reg         tx_dma_request_out,
    output reg         tx_error_summary_out
);

    // reset synchroniser
    reg         rst_meta;
    reg         rst_sync_b;

    // frame sync pin synchroniser and edge detect
    reg         sync_meta;
    reg         sync_stable;
    reg         sync_prev;
    wire        frame_start_pulse;

    // registers
    reg  [31:0] tx_slot_activity_mask;
    reg  [7:0]  tx_interrupt_enable;
    reg  [8:0]  frame_last_index;
    reg  [7:0]  tx_status;
    reg  [7:0]  next_tx_status;

    // slot counter view
    wire [8:0]  slot_index;
    wire        slot_running;
    wire        slot_at_last;
    wire        slot_active;

    // event vector in enable-register layout
    reg  [7:0]  cond_set;
    wire [7:0]  w1c_bits;
    wire        status_wr;
    wire        error_summary;
    reg  [31:0] next_rdata;

    // decode of one register offset, used for every register
    function addr_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // status register image built from the internal flags
    function [31:0] status_image;
        input [7:0] flags;
        input       active;
        input       summary;
        begin
            status_image = 32'h0000_0000;
            status_image[`TXSM_ST_UNDERRUN]    = flags[`TXSM_BIT_UNDERRUN];
            status_image[`TXSM_ST_UNEXP_SYNC]  = flags[`TXSM_BIT_UNEXP_SYNC];
            status_image[`TXSM_ST_CLK_FAIL]    = flags[`TXSM_BIT_CLK_FAIL];
            status_image[`TXSM_ST_SLOT_ACTIVE] = active;
            status_image[`TXSM_ST_FINAL_SLOT]  = flags[`TXSM_BIT_FINAL_SLOT];
            status_image[`TXSM_ST_BUF_READY]   = flags[`TXSM_BIT_BUF_READY];
            status_image[`TXSM_ST_FRAME_START] = flags[`TXSM_BIT_FRAME_START];
            status_image[`TXSM_ST_PORT_ERR]    = flags[`TXSM_BIT_PORT_ERR];
            status_image[`TXSM_ST_ERR_SUMMARY] = summary;
        end
    endfunction

    // reset release through two flip-flops; not frozen by the clock enable
    // so that reset can always be released
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // frame sync comes from the far party, so it is synchronised first
    always @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sync_meta   <= 1'b0;
            sync_stable <= 1'b0;
            sync_prev   <= 1'b0;
        end else if (clk_en_in) begin
            sync_meta   <= tx_frame_sync_in;
            sync_stable <= sync_meta;
            sync_prev   <= sync_stable;
        end
    end

    assign frame_start_pulse = sync_stable && !sync_prev;

    txsm_slot_counter u_slot_counter (
        .clk_sys_in     (clk_sys_in),
        .rst_b_in       (rst_sync_b),
        .clk_en_in      (clk_en_in),
        .frame_start_in (frame_start_pulse),
        .slot_tick_in   (slot_tick_in),
        .last_index_in  (frame_last_index),
        .slot_index_out (slot_index),
        .running_out    (slot_running),
        .at_last_out    (slot_at_last)
    );

    // only the low five bits pick the mask bit: slot n and n+32k share one bit
    assign slot_active = slot_running && tx_slot_activity_mask[slot_index[4:0]];

    // register writes
    always @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_slot_activity_mask <= `TXSM_RST_SLOT_MASK;
            tx_interrupt_enable   <= `TXSM_RST_INT_ENABLE;
            frame_last_index      <= `TXSM_RST_FRAME_LEN;
        end else if (clk_en_in && reg_wr_in) begin
            if (addr_hit(reg_addr_in, `TXSM_OFS_SLOT_MASK)) begin
                tx_slot_activity_mask <= reg_wdata_in;
            end
            if (addr_hit(reg_addr_in, `TXSM_OFS_INT_ENABLE)) begin
                // reserved positions are never stored
                tx_interrupt_enable <= reg_wdata_in[7:0] & `TXSM_INT_WRITE_MASK;
            end
            if (addr_hit(reg_addr_in, `TXSM_OFS_FRAME_LEN)) begin
                // stored clamped so that software reads back the length in use
                if (reg_wdata_in[8:0] > `TXSM_SLOT_MAX_LAST) begin
                    frame_last_index <= `TXSM_SLOT_MAX_LAST;
                end else begin
                    frame_last_index <= reg_wdata_in[8:0];
                end
            end
        end
    end

    // condition events gathered in the enable-register layout
    always @* begin
        cond_set = 8'h00;
        cond_set[`TXSM_BIT_UNDERRUN]    = tx_underrun_in;
        // a frame sync that lands before the final slot of a running frame
        cond_set[`TXSM_BIT_UNEXP_SYNC]  = frame_start_pulse && slot_running && !slot_at_last;
        cond_set[`TXSM_BIT_CLK_FAIL]    = tx_clock_failure_in;
        cond_set[`TXSM_BIT_PORT_ERR]    = tx_port_access_error_in;
        // final slot flag only rises together with buffer ready
        cond_set[`TXSM_BIT_FINAL_SLOT]  = tx_buffer_empty_in && slot_at_last;
        cond_set[`TXSM_BIT_BUF_READY]   = tx_buffer_empty_in;
        cond_set[`TXSM_BIT_FRAME_START] = frame_start_pulse;
    end

    assign status_wr = clk_en_in && reg_wr_in && addr_hit(reg_addr_in, `TXSM_OFS_STATUS);

    // status write bits reordered to the internal layout
    assign w1c_bits[`TXSM_BIT_UNDERRUN]    = status_wr && reg_wdata_in[`TXSM_ST_UNDERRUN];
    assign w1c_bits[`TXSM_BIT_UNEXP_SYNC]  = status_wr && reg_wdata_in[`TXSM_ST_UNEXP_SYNC];
    assign w1c_bits[`TXSM_BIT_CLK_FAIL]    = status_wr && reg_wdata_in[`TXSM_ST_CLK_FAIL];
    assign w1c_bits[`TXSM_BIT_PORT_ERR]    = status_wr && reg_wdata_in[`TXSM_ST_PORT_ERR];
    assign w1c_bits[`TXSM_BIT_FINAL_SLOT]  = status_wr && reg_wdata_in[`TXSM_ST_FINAL_SLOT];
    assign w1c_bits[`TXSM_BIT_BUF_READY]   = status_wr && reg_wdata_in[`TXSM_ST_BUF_READY];
    assign w1c_bits[`TXSM_BIT_RESERVED]    = 1'b0;
    assign w1c_bits[`TXSM_BIT_FRAME_START] = status_wr && reg_wdata_in[`TXSM_ST_FRAME_START];

    // sticky flags: set has priority over a write-one clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            always @* begin
                if (gi == `TXSM_BIT_RESERVED) begin
                    next_tx_status[gi] = 1'b0;
                end else if (cond_set[gi]) begin
                    next_tx_status[gi] = 1'b1;
                end else if (w1c_bits[gi]) begin
                    next_tx_status[gi] = 1'b0;
                end else begin
                    next_tx_status[gi] = tx_status[gi];
                end
            end
        end
    endgenerate

    always @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_status <= 8'h00;
        end else if (clk_en_in) begin
            tx_status <= next_tx_status;
        end
    end

    assign error_summary = tx_status[`TXSM_BIT_UNDERRUN] | tx_status[`TXSM_BIT_UNEXP_SYNC]
                         | tx_status[`TXSM_BIT_CLK_FAIL] | tx_status[`TXSM_BIT_PORT_ERR];

    // read path: data stand in the cycle after the strobe only
    always @* begin
        next_rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            if (addr_hit(reg_addr_in, `TXSM_OFS_SLOT_MASK)) begin
                next_rdata = tx_slot_activity_mask;
            end else if (addr_hit(reg_addr_in, `TXSM_OFS_INT_ENABLE)) begin
                next_rdata = {24'h00_0000, tx_interrupt_enable};
            end else if (addr_hit(reg_addr_in, `TXSM_OFS_STATUS)) begin
                next_rdata = status_image(tx_status, slot_active, error_summary);
            end else if (addr_hit(reg_addr_in, `TXSM_OFS_FRAME_LEN)) begin
                next_rdata = {23'h00_0000, frame_last_index};
            end
        end
    end

    always @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // outputs, each from a flip-flop
    always @(posedge clk_sys_in or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx_slot_active_bit_out <= 1'b0;
            tx_slot_index_out      <= 9'h000;
            tx_final_slot_out      <= 1'b0;
            tx_interrupt_out       <= 1'b0;
            tx_dma_request_out     <= 1'b0;
            tx_error_summary_out   <= 1'b0;
        end else if (clk_en_in) begin
            tx_slot_active_bit_out <= slot_active;
            tx_slot_index_out      <= slot_index;
            tx_final_slot_out      <= slot_at_last;
            // one OR over flag AND enable; reserved bit 6 is never set
            tx_interrupt_out       <= |(next_tx_status & tx_interrupt_enable);
            // dma request ignores the enable register entirely
            tx_dma_request_out     <= cond_set[`TXSM_BIT_BUF_READY];
            tx_error_summary_out   <= next_tx_status[`TXSM_BIT_UNDERRUN] | next_tx_status[`TXSM_BIT_UNEXP_SYNC]
                                    | next_tx_status[`TXSM_BIT_CLK_FAIL] | next_tx_status[`TXSM_BIT_PORT_ERR];
        end
    end

endmodule

// ==== txsm_codec_model.sv ====
// far-side serial partner: frame sync and slot boundary strobes
`timescale 1ns/10ps

module txsm_codec_model (
    // clock
    input  wire clk_sys_in,
    // serial side towards the block
    output reg  frame_sync_out,
    output reg  slot_tick_out
);
    // idle cycles after each tick; raise it to act as a slow partner
    integer gap = 2;

    initial begin
        frame_sync_out = 1'b0;
        slot_tick_out  = 1'b0;
    end

    // sync held two cycles so the synchroniser sees a clean edge
    task sync_pulse;
        begin
            @(posedge clk_sys_in);
            frame_sync_out <= 1'b1;
            repeat (2) @(posedge clk_sys_in);
            frame_sync_out <= 1'b0;
        end
    endtask

    task tick;
        begin
            @(posedge clk_sys_in);
            slot_tick_out <= 1'b1;
            @(posedge clk_sys_in);
            slot_tick_out <= 1'b0;
            repeat (gap) @(posedge clk_sys_in);
        end
    endtask
endmodule

// ==== txsm_checker.sv ====
// port-level assertions for the transmit slot mask and interrupt block
`timescale 1ns/10ps

module txsm_checker (
    // clock and reset
    input wire        clk_sys_in,
    input wire        clk_en_in,
    input wire        rst_b_in,
    // register port
    input wire [7:0]  reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [31:0] reg_rdata_out,
    // events and results
    input wire        tx_buffer_empty_in,
    input wire        tx_underrun_in,
    input wire        tx_slot_active_bit_out,
    input wire [8:0]  tx_slot_index_out,
    input wire        tx_final_slot_out,
    input wire        tx_interrupt_out,
    input wire        tx_dma_request_out
);
    // shadows of the writable registers, updated on the design's own edge
    reg [31:0] mask;
    reg [7:0]  en;
    reg [8:0]  last_idx;

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mask     <= 32'h0;
            en       <= 8'h0;
            last_idx <= 9'h0;
        end else if (reg_wr_in && clk_en_in) begin
            if (reg_addr_in == 8'hb8)
                mask <= reg_wdata_in;
            if (reg_addr_in == 8'hbc)
                en <= reg_wdata_in[7:0] & 8'hbf;
            if (reg_addr_in == 8'hc4)
                last_idx <= (reg_wdata_in[8:0] > 9'h17f) ? 9'h17f : reg_wdata_in[8:0];
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_dma_after_ready: assert property (
        tx_buffer_empty_in && clk_en_in |=> tx_dma_request_out) else $error("dma request missing");
    a_dma_has_cause: assert property (
        tx_dma_request_out |-> $past(tx_buffer_empty_in)) else $error("dma request without cause");
    a_underrun_irq: assert property (
        tx_underrun_in && clk_en_in && en[0] |=> tx_interrupt_out) else $error("underrun gave no interrupt");
    a_irq_needs_enable: assert property (
        en == 8'h00 && $past(en) == 8'h00 |-> !tx_interrupt_out) else $error("interrupt with no enable");
    a_mask_gates_slot: assert property (
        tx_slot_active_bit_out && !$past(reg_wr_in) |-> mask[tx_slot_index_out[4:0]])
        else $error("active slot masked off");
    a_final_at_last: assert property (
        tx_final_slot_out && !$past(reg_wr_in) |-> tx_slot_index_out == last_idx)
        else $error("final slot at wrong index");
    a_index_in_range: assert property (
        tx_slot_index_out <= 9'h17f) else $error("slot index out of range");
    a_enable_reserved: assert property (
        $past(reg_rd_in && reg_addr_in == 8'hbc) |-> reg_rdata_out[31:8] == 24'h0 && !reg_rdata_out[6])
        else $error("reserved enable bits nonzero");
endmodule

bind txsm_top txsm_checker i_txsm_checker (
    .clk_sys_in, .clk_en_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .tx_buffer_empty_in, .tx_underrun_in, .tx_slot_active_bit_out,
    .tx_slot_index_out, .tx_final_slot_out, .tx_interrupt_out, .tx_dma_request_out
);

// ==== tx_slot_mask_and_irq_enable_test.sv ====
// self-checking bench for the transmit slot mask and interrupt block
`timescale 1ns/10ps

module tx_slot_mask_and_irq_enable_test;
    reg         clk_sys_in = 1'b0;
    reg         clk_en_in = 1'b1;
    reg         rst_b_in = 1'b0;
    reg  [7:0]  reg_addr_in = 8'h00;
    reg  [31:0] reg_wdata_in = 32'h0;
    reg         reg_wr_in = 1'b0;
    reg         reg_rd_in = 1'b0;
    reg  [3:0]  ev = 4'h0;
    wire [31:0] reg_rdata_out;
    wire        fsync, tick, act, fin, irq, dma, summ;
    wire [8:0]  idx;
    reg  [31:0] rv;
    integer     err_total = 0;
    integer     total_checks = 0;
    integer     cyc = 0;
    integer     i, s, e;

    txsm_top i_txsm_top (
        .clk_sys_in, .clk_en_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .tx_frame_sync_in(fsync), .slot_tick_in(tick), .tx_buffer_empty_in(ev[0]),
        .tx_underrun_in(ev[1]), .tx_clock_failure_in(ev[2]), .tx_port_access_error_in(ev[3]),
        .tx_slot_active_bit_out(act), .tx_slot_index_out(idx), .tx_final_slot_out(fin),
        .tx_interrupt_out(irq), .tx_dma_request_out(dma), .tx_error_summary_out(summ)
    );
    txsm_codec_model i_txsm_codec_model (.clk_sys_in, .frame_sync_out(fsync), .slot_tick_out(tick));

    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // the ceiling is far above the few hundred cycles the tests need
    always @(posedge clk_sys_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            close_out;
        end
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("BAD t=%0t seen %h want %h", $time, seen, exp);
            end
        end
    endtask

    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk_sys_in);
            #1;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys_in);
            reg_addr_in  <= a;
            reg_wdata_in <= d;
            reg_wr_in    <= 1'b1;
            @(posedge clk_sys_in);
            reg_wr_in <= 1'b0;
        end
    endtask

    task rd(input [7:0] a);
        begin
            @(posedge clk_sys_in);
            reg_addr_in <= a;
            reg_rd_in   <= 1'b1;
            @(posedge clk_sys_in);
            reg_rd_in <= 1'b0;
            #1;
            rv = reg_rdata_out;
        end
    endtask

    task pulse(input [3:0] v);
        begin
            @(posedge clk_sys_in);
            ev <= v;
            @(posedge clk_sys_in);
            ev <= 4'h0;
            #1;
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        // reset values, then one unmapped place at 0xc8
        for (i = 0; i < 5; i = i + 1) begin
            rd(8'hb8 + 8'(4 * i));
            chk(rv, 32'h0);
        end
        wr(8'hb8, 32'ha5a5_5a5a);
        rd(8'hb8);
        chk(rv, 32'ha5a5_5a5a);
        wr(8'hbc, 32'hffff_ffff);
        rd(8'hbc);
        chk(rv, 32'hbf);
        wr(8'hc4, 32'h1ff);
        rd(8'hc4);
        chk(rv, 32'h17f);
        wr(8'hbc, 32'h0);
        $display("test registers done");
        // underrun, clock failure, port error: status bit s, enable bit e
        for (i = 0; i < 3; i = i + 1) begin
            s = (i == 2) ? 7 : 2 * i;
            e = (i == 2) ? 3 : 2 * i;
            pulse(4'h2 << i);
            chk({irq, summ}, 2'b01);
            wr(8'hbc, 32'h1 << e);
            waitc(2);
            chk(irq, 1'b1);
            wr(8'hc0, 32'h0);
            rd(8'hc0);
            chk(rv, (32'h1 << s) | 32'h100);
            wr(8'hc0, 32'h1 << s);
            waitc(2);
            chk({irq, summ}, 2'b00);
            pulse(4'h2 << i);
            chk(irq, 1'b1);
            wr(8'hc0, 32'h1 << s);
            wr(8'hbc, 32'h0);
        end
        $display("test conditions done");
        wr(8'hbc, 32'h20);
        pulse(4'h1);
        chk({dma, irq}, 2'b11);
        waitc(1);
        chk(dma, 1'b0);
        // clear and a fresh event on the same edge: the event must win
        @(posedge clk_sys_in);
        reg_addr_in  <= 8'hc0;
        reg_wdata_in <= 32'h20;
        reg_wr_in    <= 1'b1;
        ev           <= 4'h1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        ev        <= 4'h0;
        rd(8'hc0);
        chk(rv, 32'h20);
        wr(8'hc0, 32'h20);
        wr(8'hbc, 32'h0);
        pulse(4'h1);
        chk({dma, irq}, 2'b10);
        wr(8'hc0, 32'h20);
        $display("test buffer ready done");
        // 34-slot frame, mask bit 1 only, so slots 1 and 33 are active
        wr(8'hc4, 32'd33);
        wr(8'hb8, 32'h2);
        wr(8'hbc, 32'h90);
        i_txsm_codec_model.sync_pulse;
        waitc(3);
        chk(irq, 1'b1);
        wr(8'hc0, 32'h40);
        for (i = 0; i < 34; i = i + 1) begin
            chk(idx, i);
            chk(act, (i % 32) == 1);
            chk(fin, i == 33);
            if (i == 33)
                pulse(4'h1);
            i_txsm_codec_model.tick;
            #1;
        end
        chk({act, fin}, 2'b00);
        rd(8'hc0);
        chk(rv & 32'h30, 32'h30);
        chk(irq, 1'b1);
        // slow partner, then a sync in mid-frame
        i_txsm_codec_model.gap = 5;
        wr(8'hc0, 32'h70);
        wr(8'hbc, 32'h2);
        i_txsm_codec_model.sync_pulse;
        waitc(3);
        i_txsm_codec_model.tick;
        i_txsm_codec_model.tick;
        i_txsm_codec_model.sync_pulse;
        waitc(3);
        rd(8'hc0);
        chk(rv & 32'h102, 32'h102);
        chk(irq, 1'b1);
        $display("test frame done");
        close_out;
    end
endmodule
